// ===== peripheral_event_flags.sv
`timescale 1ns/1ps
`include "peripheral_event_flags_defines.svh"

module peripheral_event_flags (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // serial unit transmit side
  input wire logic tx_buffer_full,
  input wire logic tx_data_holding_reg_wr,
  // sync serial port unit events
  input wire logic ssp_xfer_done,
  input wire logic i2c_master_mode,
  input wire logic i2c_seq_done,
  input wire logic i2c_multi_master,
  input wire logic ssp_idle,
  input wire logic i2c_bus_start_stop,
  // capture/compare unit
  input wire logic [1:0] capcmp_mode,
  input wire logic first_timer_capture,
  input wire logic first_timer_match,
  // software clear strobes, one bit per flag position
  input wire logic [`FLAG_WIDTH-1:0] flag_clear,
  output logic tx_buffer_empty_flag,
  output logic serial_port_event_flag,
  output logic capture_compare_event_flag,
  output logic [`FLAG_WIDTH-1:0] flag_byte_q
);

  logic serial_set;
  logic capcmp_set;
  logic serial_q;
  logic capcmp_q;
  logic tx_empty_q;
  peripheral_event_flags_pkg::capcmp_mode_type mode;

  // every check below runs on the core clock and rests while reset is low
  default clocking core_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  assign mode = peripheral_event_flags_pkg::capcmp_mode_type'(capcmp_mode);

  // all sources that raise the serial port event
  assign serial_set = ssp_xfer_done
    | (i2c_master_mode & i2c_seq_done)
    | (i2c_multi_master & ssp_idle & i2c_bus_start_stop);

  // pwm and off modes never raise the flag
  assign capcmp_set = ((mode == peripheral_event_flags_pkg::CAPCMP_CAPTURE)
    & first_timer_capture)
    | ((mode == peripheral_event_flags_pkg::CAPCMP_COMPARE)
    & first_timer_match);

  // tx flag mirrors buffer state; a write fills the buffer, so it drops at once
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_empty_q <= 1'b0;
    end else if (clk_en) begin
      tx_empty_q <= ~tx_buffer_full & ~tx_data_holding_reg_wr;
    end
  end

  // sticky serial flag; a set in the clear cycle wins so no event is lost
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_q <= 1'b0;
    end else if (clk_en) begin
      if (serial_set) begin
        serial_q <= 1'b1;
      end else if (flag_clear[`FLAG_BIT_SERIAL_EVENT]) begin
        serial_q <= 1'b0;
      end
    end
  end

  // sticky capture/compare flag, set wins over clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      capcmp_q <= 1'b0;
    end else if (clk_en) begin
      if (capcmp_set) begin
        capcmp_q <= 1'b1;
      end else if (flag_clear[`FLAG_BIT_CAPCMP_EVENT]) begin
        capcmp_q <= 1'b0;
      end
    end
  end

  // registered copies for the outputs and the readable byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_buffer_empty_flag <= 1'b0;
      serial_port_event_flag <= 1'b0;
      capture_compare_event_flag <= 1'b0;
      flag_byte_q <= `FLAG_RESET_BYTE;
    end else if (clk_en) begin
      tx_buffer_empty_flag <= tx_empty_q;
      serial_port_event_flag <= serial_q;
      capture_compare_event_flag <= capcmp_q;
      flag_byte_q <= `FLAG_RESET_BYTE;
      flag_byte_q[`FLAG_BIT_TX_EMPTY] <= tx_empty_q;
      flag_byte_q[`FLAG_BIT_SERIAL_EVENT] <= serial_q;
      flag_byte_q[`FLAG_BIT_CAPCMP_EVENT] <= capcmp_q;
    end
  end

  // assertions: an event is taken on an enabled edge and lands in the internal flag; the
  // pins copy it on the next enabled edge, so pin checks wait for that second enable
  sequence seq_serial_taken;
    clk_en && serial_set;
  endsequence : seq_serial_taken

  sequence seq_serial_shown;
    (clk_en && serial_set) ##1 clk_en;
  endsequence : seq_serial_shown

  sequence seq_i2c_seq_shown;
    (clk_en && i2c_master_mode && i2c_seq_done) ##1 clk_en;
  endsequence : seq_i2c_seq_shown

  sequence seq_idle_bus_taken;
    clk_en && i2c_multi_master && ssp_idle && i2c_bus_start_stop;
  endsequence : seq_idle_bus_taken

  sequence seq_capture_taken;
    clk_en && mode == peripheral_event_flags_pkg::CAPCMP_CAPTURE && first_timer_capture;
  endsequence : seq_capture_taken

  sequence seq_compare_taken;
    clk_en && mode == peripheral_event_flags_pkg::CAPCMP_COMPARE && first_timer_match;
  endsequence : seq_compare_taken

  sequence seq_tx_write_shown;
    (clk_en && tx_data_holding_reg_wr) ##1 clk_en;
  endsequence : seq_tx_write_shown

  sequence seq_tx_full_shown;
    (clk_en && tx_buffer_full) ##1 clk_en;
  endsequence : seq_tx_full_shown

  // setting conditions, internal and at the pins
  chk_serial_set_sticks: assert property (
    seq_serial_taken |=> serial_q)
    else $error("serial event flag not set after event");

  chk_serial_pin_sets: assert property (
    seq_serial_shown |=> serial_port_event_flag && flag_byte_q[`FLAG_BIT_SERIAL_EVENT])
    else $error("serial event flag not shown on the pins");

  chk_i2c_seq_sets: assert property (
    seq_i2c_seq_shown |=> serial_port_event_flag)
    else $error("i2c sequence end did not raise flag");

  chk_idle_bus_sets: assert property (
    seq_idle_bus_taken |=> serial_q)
    else $error("idle bus condition did not raise flag");

  chk_capture_sets: assert property (
    seq_capture_taken |=> capcmp_q)
    else $error("capture did not raise flag");

  chk_compare_sets: assert property (
    seq_compare_taken |=> capcmp_q)
    else $error("compare match did not raise flag");

  // transmit flag follows the buffer; a data write drops it at once
  chk_tx_write_clears: assert property (
    clk_en && tx_data_holding_reg_wr |=> !tx_empty_q)
    else $error("tx flag not cleared by data write");

  chk_tx_write_pin: assert property (
    seq_tx_write_shown |=> !tx_buffer_empty_flag && !flag_byte_q[`FLAG_BIT_TX_EMPTY])
    else $error("tx flag pin not cleared by data write");

  chk_tx_full_zero: assert property (
    seq_tx_full_shown |=> !tx_buffer_empty_flag)
    else $error("tx flag high while buffer full");

  chk_tx_empty_one: assert property (
    clk_en && !tx_buffer_full && !tx_data_holding_reg_wr |=> tx_empty_q)
    else $error("tx flag low while buffer empty");

  // sticky behaviour; off and pwm modes must never raise the capture/compare flag
  chk_serial_holds: assert property (
    clk_en && serial_q && !flag_clear[`FLAG_BIT_SERIAL_EVENT] |=> serial_q)
    else $error("serial event flag dropped without clear");

  chk_serial_clear: assert property (
    clk_en && flag_clear[`FLAG_BIT_SERIAL_EVENT] && !serial_set |=> !serial_q)
    else $error("serial event flag did not clear");

  chk_capcmp_holds: assert property (
    clk_en && capcmp_q && !flag_clear[`FLAG_BIT_CAPCMP_EVENT] |=> capcmp_q)
    else $error("capture/compare flag dropped without clear");

  chk_capcmp_clear: assert property (
    clk_en && flag_clear[`FLAG_BIT_CAPCMP_EVENT] && !capcmp_set |=> !capcmp_q)
    else $error("capture/compare flag did not clear");

  chk_capcmp_quiet: assert property (
    clk_en && !capcmp_q && (mode == peripheral_event_flags_pkg::CAPCMP_OFF
    || mode == peripheral_event_flags_pkg::CAPCMP_PWM) |=> !capcmp_q)
    else $error("capture/compare flag raised in off or pwm mode");

  // a low enable freezes all state; otherwise the pins copy the internal flags
  chk_freeze_hold: assert property (
    !clk_en |=> $stable(tx_empty_q) && $stable(serial_q) && $stable(capcmp_q)
    && $stable(flag_byte_q) && $stable(tx_buffer_empty_flag)
    && $stable(serial_port_event_flag) && $stable(capture_compare_event_flag))
    else $error("state moved while clock enable low");

  chk_out_tx_follows: assert property (
    clk_en |=> tx_buffer_empty_flag == $past(tx_empty_q)
    && flag_byte_q[`FLAG_BIT_TX_EMPTY] == $past(tx_empty_q))
    else $error("tx flag pins differ from internal flag");

  chk_out_serial_follows: assert property (
    clk_en |=> serial_port_event_flag == $past(serial_q)
    && flag_byte_q[`FLAG_BIT_SERIAL_EVENT] == $past(serial_q))
    else $error("serial flag pins differ from internal flag");

  chk_out_capcmp_follows: assert property (
    clk_en |=> capture_compare_event_flag == $past(capcmp_q)
    && flag_byte_q[`FLAG_BIT_CAPCMP_EVENT] == $past(capcmp_q))
    else $error("capture/compare flag pins differ from internal flag");

endmodule : peripheral_event_flags

// ===== peripheral_event_flags_defines.svh
`ifndef PERIPHERAL_EVENT_FLAGS_DEFINES_SVH
`define PERIPHERAL_EVENT_FLAGS_DEFINES_SVH

// positions of the flags within the flag register, bits 2 to 4
`define FLAG_BIT_TX_EMPTY 4
`define FLAG_BIT_SERIAL_EVENT 3
`define FLAG_BIT_CAPCMP_EVENT 2
`define FLAG_WIDTH 8
// reset values
`define FLAG_RESET_BYTE 8'h00
`define CAPCMP_MODE_RESET 2'h0

`endif

// ===== peripheral_event_flags_pkg.sv
package peripheral_event_flags_pkg;

  // operating mode of the capture/compare unit
  typedef enum logic [1:0] {
    CAPCMP_OFF = 2'b00,
    CAPCMP_CAPTURE = 2'b01,
    CAPCMP_COMPARE = 2'b10,
    CAPCMP_PWM = 2'b11
  } capcmp_mode_type;

endpackage : peripheral_event_flags_pkg

// ===== serial_tx_stub.sv
`timescale 1ns/1ps
module serial_tx_stub (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wr,
  output logic tx_buffer_full
);
  logic [2:0] cnt_q;
  // a written byte sits in the buffer six cycles; a rewrite restarts the shift
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 3'h0;
    else if (wr) cnt_q <= 3'h6;
    else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
  end
  assign tx_buffer_full = (cnt_q != 3'h0);
endmodule : serial_tx_stub

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic full, tx_f, ser_f, cc_f, es, ec, et;
  logic [19:0] v = 20'h0;
  logic [7:0] fb;
  logic [31:0] r;
  logic [19:0] corner [15] = '{20'h80002, 20'h84002, 20'h84000, 20'h80008, 20'h8000c,
    20'h84000, 20'h80050, 20'h80070, 20'h80280, 20'h82000, 20'h80500, 20'h82780, 20'h80600,
    20'h84000, 20'h00002};
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #50 ref_clk = ~ref_clk;
  serial_tx_stub u_stub (.ref_clk(ref_clk), .rst_n(rst_n), .wr(v[0]), .tx_buffer_full(full));
  peripheral_event_flags u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(v[19]),
    .tx_buffer_full(full), .tx_data_holding_reg_wr(v[0]), .ssp_xfer_done(v[1]),
    .i2c_master_mode(v[2]), .i2c_seq_done(v[3]), .i2c_multi_master(v[4]), .ssp_idle(v[5]),
    .i2c_bus_start_stop(v[6]), .capcmp_mode(v[8:7]), .first_timer_capture(v[9]),
    .first_timer_match(v[10]), .flag_clear(v[18:11]), .tx_buffer_empty_flag(tx_f),
    .serial_port_event_flag(ser_f), .capture_compare_event_flag(cc_f), .flag_byte_q(fb));
  // next sticky pair {serial, capcmp}; a set beats a clear in the same cycle
  function automatic logic [1:0] nxt(input logic [19:0] s, input logic [1:0] cur);
    logic ser, cc;
    ser = s[1] | (s[2] & s[3]) | (s[4] & s[5] & s[6]);
    cc = (s[8:7] == peripheral_event_flags_pkg::CAPCMP_CAPTURE && s[9]) ||
      (s[8:7] == peripheral_event_flags_pkg::CAPCMP_COMPARE && s[10]);
    if (!s[19]) return cur;
    return {ser | (cur[1] & !s[14]), cc | (cur[0] & !s[13])};
  endfunction : nxt
  task check_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_byte
  // one-cycle request, then pulses dropped and levels kept while the flags settle
  task step(input logic [19:0] s);
    @(posedge ref_clk) v <= s;
    @(posedge ref_clk) v <= s & 20'h801b4;
    repeat (4) @(posedge ref_clk);
    #1 {es, ec} = nxt(s, {es, ec});
    // a low enable freezes the tx flag, though the buffer model drains on regardless
    if (s[19]) et = !full;
    check_byte(fb, {3'h0, et, es, ec, 2'h0});
    check_byte({5'h0, tx_f, ser_f, cc_f}, {5'h0, et, es, ec});
  endtask : step
  task wrap_up;
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // hang guard: the whole sequence needs well under two thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    {es, ec} = 2'h0;
    et = 1'h0;
    void'($urandom(32'ha8103c15));
    repeat (6) @(posedge ref_clk);
    #1 check_byte(fb, 8'h00);
    rst_n <= 1'b1;
    foreach (corner[i]) step(corner[i]);
    step(20'h80001);
    $display("test corners done");
    repeat (200) begin
      r = $urandom;
      step({r[20] | r[21], r[18:0]});
    end
    $display("test random done");
    @(posedge ref_clk) rst_n <= 1'b0;
    @(posedge ref_clk) #1 check_byte({fb[7:5], fb[4:0] | {tx_f, ser_f, cc_f}}, 8'h00);
    rst_n <= 1'b1;
    {es, ec} = 2'h0;
    et = 1'h0;
    step(20'h80000);
    $display("test reset done");
    wrap_up();
  end
endmodule : testbench
